// File: src/irq_unit_pkg.sv
// Package for the six-source vectored interrupt unit.
// Assumes an 8-bit data memory bus from the core and a 12-bit program counter.
package irq_unit_pkg;
  localparam int         NUM_SRC       = 6;
  localparam logic [7:0] ADDR_CTRL_LOW  = 8'h0B;
  localparam logic [7:0] ADDR_CTRL_HIGH = 8'h1E;
  // Control low field positions
  localparam int LOW_GIE       = 0;
  localparam int LOW_EN_BASE   = 1;
  localparam int LOW_PEND_BASE = 4;
  localparam int LOW_TEST      = 7;
  // Control high field positions
  localparam int HIGH_EN_BASE   = 0;
  localparam int HIGH_PEND_BASE = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Vectors, index 0 is highest priority
  localparam logic [11:0] VEC_BASE = 12'h004;
  localparam logic [11:0] VEC_STEP = 12'h004;
  // Trigger modes of the external pins
  localparam logic [1:0] TRIG_FALL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_BOTH = 2'h2;
endpackage : irq_unit_pkg

// File: src/irq_flags_if.sv
// Carrier between the arbiter and the top of the interrupt unit.
// Assumes one clock domain.
`timescale 1ns/1ps
interface irq_flags_if;
  logic [5:0]  pending;
  logic [5:0]  enable;
  logic        grant_valid;
  logic [2:0]  grant_idx;
  logic [11:0] grant_vec;
  modport top (output pending, output enable, input grant_valid, input grant_idx,
               input grant_vec);
  modport arb (input pending, input enable, output grant_valid, output grant_idx,
               output grant_vec);
endinterface : irq_flags_if

// File: src/irq_priority_arbiter.sv
// Fixed-priority selector for the interrupt unit.
// Assumes pending and enable are stable flops on the same clock.
`timescale 1ns/1ps
module irq_priority_arbiter
  import irq_unit_pkg::*;
(
  irq_flags_if.arb flags
);
  // Lowest index wins
  always_comb begin
    flags.grant_valid = 1'b0;
    flags.grant_idx   = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (flags.pending[i] && flags.enable[i]) begin
        flags.grant_valid = 1'b1;
        flags.grant_idx   = 3'(i);
      end
    end
    flags.grant_vec = VEC_BASE + VEC_STEP * 12'(flags.grant_idx);
  end
endmodule : irq_priority_arbiter

// File: src/irq_unit_top.sv
// Vectored interrupt unit with two control registers in data memory.
// Assumes the core issues phase_two_pulse once per instruction and accepts
// a one-cycle vector_take pulse at that boundary.
`timescale 1ns/1ps
module irq_unit_top
  import irq_unit_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        phase_two_pulse,
  input  wire logic        stack_full,
  input  wire logic        return_from_irq,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  input  wire logic        ext0_pin,
  input  wire logic        ext1_pin,
  input  wire logic [1:0]  ext0_trigger,
  input  wire logic [1:0]  ext1_trigger,
  input  wire logic        timer_overflow,
  input  wire logic        tick_timeout,
  input  wire logic        conv_done,
  input  wire logic        clock_tick_timeout,
  output logic             vector_take,
  output logic      [11:0] vector_addr
);
  // ****************************************************************
  // Synchronisers and edge detection
  // ****************************************************************
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic [1:0] pin_last_q;
  logic [2:0] sync_fill_q;
  logic [1:0] ext_edge;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_q  <= 2'h0;
      pin_sync_q  <= 2'h0;
      pin_last_q  <= 2'h0;
      sync_fill_q <= 3'h0;
    end else begin
      pin_meta_q  <= {ext1_pin, ext0_pin};
      pin_sync_q  <= pin_meta_q;
      pin_last_q  <= pin_sync_q;
      sync_fill_q <= {sync_fill_q[1:0], 1'b1};
    end
  end

  function automatic logic edge_hit(input logic now, input logic last, input logic [1:0] trig);
    logic rise;
    logic fall;
    rise = now & ~last;
    fall = ~now & last;
    case (trig)
      TRIG_FALL: edge_hit = fall;
      TRIG_RISE: edge_hit = rise;
      TRIG_BOTH: edge_hit = rise | fall;
      default:   edge_hit = fall;
    endcase
  endfunction : edge_hit

  // Trigger inputs are static configuration, so no synchroniser
  // No edges until the chain holds real pin samples, so a pin idling high is no event
  assign ext_edge[0] = edge_hit(pin_sync_q[0], pin_last_q[0], ext0_trigger)
                       & sync_fill_q[2];
  assign ext_edge[1] = edge_hit(pin_sync_q[1], pin_last_q[1], ext1_trigger)
                       & sync_fill_q[2];

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic       global_irq_enable_q;
  logic       test_bit_q;
  logic [5:0] enable_q;
  logic [5:0] pending_q;
  logic [5:0] pending_d;
  logic [5:0] hw_set;
  logic [5:0] serviced;
  logic       wr_low;
  logic       wr_high;
  logic       take;
  irq_flags_if flags ();

  assign wr_low  = mem_wr && (mem_addr == ADDR_CTRL_LOW);
  assign wr_high = mem_wr && (mem_addr == ADDR_CTRL_HIGH);
  assign hw_set  = {clock_tick_timeout, conv_done, tick_timeout, timer_overflow, ext_edge};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enable_q   <= 6'h00;
      test_bit_q <= 1'b0;
    end else begin
      if (wr_low) begin
        enable_q[2:0] <= mem_wdata[LOW_EN_BASE +: 3];
        test_bit_q    <= mem_wdata[LOW_TEST];  // Stored only, has no effect
      end
      if (wr_high) begin
        enable_q[5:3] <= mem_wdata[HIGH_EN_BASE +: 3];
      end
    end
  end

  // Write first, then service clear, then hardware set on top
  always_comb begin
    pending_d = pending_q;
    if (wr_low) begin
      pending_d[2:0] = mem_wdata[LOW_PEND_BASE +: 3];
    end
    if (wr_high) begin
      pending_d[5:3] = mem_wdata[HIGH_PEND_BASE +: 3];
    end
    pending_d = (pending_d & ~serviced) | hw_set;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pending_q <= 6'h00;
    end else begin
      pending_q <= pending_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      global_irq_enable_q <= 1'b0;
    end else if (take) begin
      global_irq_enable_q <= 1'b0;
    end else if (return_from_irq) begin
      global_irq_enable_q <= 1'b1;
    end else if (wr_low) begin
      global_irq_enable_q <= mem_wdata[LOW_GIE];
    end
  end

  // ****************************************************************
  // Arbitration and vectoring
  // ****************************************************************
  assign flags.pending = pending_q;
  assign flags.enable  = enable_q;

  irq_priority_arbiter u_arb (
    .flags (flags)
  );

  // Only at the phase boundary, globally enabled and with stack room
  assign take = phase_two_pulse && global_irq_enable_q && !stack_full
                && flags.grant_valid;
  assign serviced = take ? 6'(6'h01 << flags.grant_idx) : 6'h00;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      vector_take <= 1'b0;
      vector_addr <= 12'h000;
    end else begin
      vector_take <= take;
      if (take) begin
        vector_addr <= flags.grant_vec;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (mem_rd && mem_addr == ADDR_CTRL_LOW) begin
      rdata_d = {test_bit_q, pending_q[2:0], enable_q[2:0], global_irq_enable_q};
    end else if (mem_rd && mem_addr == ADDR_CTRL_HIGH) begin
      rdata_d = {1'b0, pending_q[5:3], 1'b0, enable_q[5:3]};
    end
  end

  // Read data leaves a flop, so it stands one cycle after the request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_rdata <= 8'h00;
    end else begin
      mem_rdata <= rdata_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_no_take_off_phase;
    @(posedge sys_clk) disable iff (!rstn) !phase_two_pulse |-> ##1 !vector_take;
  endproperty
  a_no_take_off_phase: assert property (p_no_take_off_phase)
    else $error("take outside phase pulse");

  property p_serve_at_phase;
    @(posedge sys_clk) disable iff (!rstn)
      phase_two_pulse && global_irq_enable_q && !stack_full
      && (pending_q & enable_q) != 6'h00 |-> ##1 vector_take;
  endproperty
  a_serve_at_phase: assert property (p_serve_at_phase)
    else $error("enabled request not served at phase pulse");

  property p_gie_gate;
    @(posedge sys_clk) disable iff (!rstn) !global_irq_enable_q |-> ##1 !vector_take;
  endproperty
  a_gie_gate: assert property (p_gie_gate)
    else $error("vector taken with global enable clear");

  property p_stack_full;
    @(posedge sys_clk) disable iff (!rstn) stack_full |-> ##1 !vector_take;
  endproperty
  a_stack_full: assert property (p_stack_full)
    else $error("vector taken with stack full");

  property p_clear_gie;
    @(posedge sys_clk) disable iff (!rstn) vector_take |-> !global_irq_enable_q;
  endproperty
  a_clear_gie: assert property (p_clear_gie)
    else $error("global enable still set after vector");

  property p_vec_ext0;
    @(posedge sys_clk) disable iff (!rstn)
      take && pending_q[0] && enable_q[0] |-> ##1 vector_addr == 12'h004;
  endproperty
  a_vec_ext0: assert property (p_vec_ext0)
    else $error("ext0 not given priority");

  property p_vec_tick;
    @(posedge sys_clk) disable iff (!rstn)
      take && (pending_q[2:0] & enable_q[2:0]) == 3'h0 && pending_q[3] && enable_q[3]
      |-> ##1 vector_addr == 12'h010;
  endproperty
  a_vec_tick: assert property (p_vec_tick)
    else $error("tick vector wrong");

  property p_flag_holds;
    @(posedge sys_clk) disable iff (!rstn)
      pending_q[5] && !take && !wr_high |-> ##1 pending_q[5];
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flag dropped without service or write");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rstn) wr_high && conv_done |-> ##1 pending_q[4];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost under software clear");

  property p_return_from_irq;
    @(posedge sys_clk) disable iff (!rstn) return_from_irq && !take |-> ##1 global_irq_enable_q;
  endproperty
  a_return_from_irq: assert property (p_return_from_irq)
    else $error("return from irq did not set global enable");

  property p_high_zero;
    @(posedge sys_clk) disable iff (!rstn)
      mem_rd && mem_addr == ADDR_CTRL_HIGH |-> ##1 mem_rdata[3] == 1'b0 && mem_rdata[7] == 1'b0;
  endproperty
  a_high_zero: assert property (p_high_zero)
    else $error("unused high bits not zero");
endmodule : irq_unit_top

// File: verif/core_seq_model.sv
// Stand-in for the core sequencer: one phase-two pulse per instruction.
// Assumes the unit samples the pulse on the same rising clock edge.
`timescale 1ns/1ps
module core_seq_model #(
  parameter int PERIOD = 4
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic slow,
  output logic      phase_two_pulse
);
  int cnt_q;

  // Slow mode doubles the instruction length, so requests wait longer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 0;
      phase_two_pulse <= 1'b0;
    end else begin
      phase_two_pulse <= (cnt_q == 0);
      cnt_q <= (cnt_q >= (slow ? 2 * PERIOD : PERIOD) - 1) ? 0 : cnt_q + 1;
    end
  end
endmodule : core_seq_model

// File: verif/test_six_source_vectored_irq_unit.sv
// Self-checking bench for the six-source vectored interrupt unit.
// Assumes the design package, carrier and core stand-in are compiled first.
`timescale 1ns/1ps
module test_six_source_vectored_irq_unit;
  import irq_unit_pkg::*;
  logic        sys_clk, rstn, stack_full, return_from_irq, mem_wr, mem_rd, slow;
  logic        ext0_pin, ext1_pin, timer_overflow, tick_timeout, conv_done;
  logic        clock_tick_timeout, phase_two_pulse, vector_take;
  logic [1:0]  ext0_trigger, ext1_trigger;
  logic [7:0]  mem_addr, mem_wdata, mem_rdata, d;
  logic [11:0] vector_addr;
  int          miscompares, checked, takes, t0, pend, gie, idx, i, seed;

  always #50 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (vector_take === 1'b1) takes <= takes + 1;

  core_seq_model core_seq_model_inst (.sys_clk(sys_clk), .rstn(rstn), .slow(slow),
    .phase_two_pulse(phase_two_pulse));
  irq_unit_top irq_unit_top_inst (.sys_clk(sys_clk), .rstn(rstn),
    .phase_two_pulse(phase_two_pulse), .stack_full(stack_full),
    .return_from_irq(return_from_irq), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .ext0_pin(ext0_pin), .ext1_pin(ext1_pin), .ext0_trigger(ext0_trigger),
    .ext1_trigger(ext1_trigger), .timer_overflow(timer_overflow),
    .tick_timeout(tick_timeout), .conv_done(conv_done),
    .clock_tick_timeout(clock_tick_timeout), .vector_take(vector_take),
    .vector_addr(vector_addr));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results;
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // Called at a falling edge; one rising edge takes it, then a falling edge idles the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    mem_wr = 1'b1;
    mem_addr = a;
    mem_wdata = v;
    @(negedge sys_clk);
    mem_wr = 1'b0;
    @(negedge sys_clk);
  endtask : wr

  // Read data is registered, so it stands at the falling edge after the request
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    mem_rd = 1'b1;
    mem_addr = a;
    @(negedge sys_clk);
    chk({4'h0, mem_rdata}, {4'h0, exp});
    mem_rd = 1'b0;
    @(negedge sys_clk);
  endtask : rd

  task automatic chk_regs;
    rd(ADDR_CTRL_LOW, {1'b0, pend[2:0], 3'b111, gie[0]});
    rd(ADDR_CTRL_HIGH, {1'b0, pend[5:3], 1'b0, 3'b111});
  endtask : chk_regs

  task automatic wait_take;
    for (int n = 0; n < 100 && takes == t0; n++) @(negedge sys_clk);
    if (takes == t0) begin
      miscompares++;
      results();
    end
  endtask : wait_take

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {sys_clk, rstn, stack_full, return_from_irq, mem_wr, mem_rd, slow} = 7'h00;
    {ext0_pin, ext1_pin, timer_overflow, tick_timeout, conv_done} = 5'h00;
    clock_tick_timeout = 1'b0;
    ext0_trigger = TRIG_FALL;
    ext1_trigger = TRIG_RISE;
    mem_addr = 8'h00;
    mem_wdata = 8'h00;
    {miscompares, checked, takes, pend, gie} = '0;
    seed = 32'hB5B0;
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    rd(ADDR_CTRL_LOW, CTRL_RESET);
    rd(ADDR_CTRL_HIGH, CTRL_RESET);
    rd(8'h0C, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed)) & 8'h7E;
      wr(ADDR_CTRL_LOW, d);
      rd(ADDR_CTRL_LOW, d);
      d = 8'($random(seed));
      wr(ADDR_CTRL_HIGH, d);
      rd(ADDR_CTRL_HIGH, d & 8'h77);
    end
    wr(ADDR_CTRL_LOW, 8'h0E);
    wr(ADDR_CTRL_HIGH, 8'h07);
    // Rising edge on a falling-trigger pin must not record anything
    ext0_pin = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk_regs();
    {ext0_pin, ext1_pin, timer_overflow, tick_timeout, conv_done} = 5'h0F;
    clock_tick_timeout = 1'b1;
    // Clearing the high flags in the very cycle of the events must lose
    fork
      wr(ADDR_CTRL_HIGH, 8'h07);
      begin
        @(negedge sys_clk);
        {timer_overflow, tick_timeout, conv_done, clock_tick_timeout} = 4'h0;
      end
    join
    repeat (5) @(negedge sys_clk);
    pend = 6'h3F;
    chk_regs();
    repeat (20) @(negedge sys_clk);
    chk(12'(takes), 12'h000);
    for (i = 0; i < 6; i++) begin
      idx = 0;
      while (!pend[idx]) idx++;
      stack_full = (i == 2);
      slow = (i > 2);
      t0 = takes;
      if (i % 2) begin
        return_from_irq = 1'b1;
        @(negedge sys_clk);
        return_from_irq = 1'b0;
        @(negedge sys_clk);
      end else
        wr(ADDR_CTRL_LOW, {1'b0, pend[2:0], 4'hF});
      if (i == 2) begin
        repeat (20) @(negedge sys_clk);
        chk(12'(takes), 12'(t0));
        stack_full = 1'b0;
      end
      wait_take();
      chk(vector_addr, 12'(VEC_BASE + VEC_STEP * 12'(idx)));
      pend[idx] = 0;
      gie = 0;
      chk_regs();
    end
    results();
  end
endmodule : test_six_source_vectored_irq_unit
